// ### rtl/can_interrupt_logic.sv
// CAN interrupt flags, masks and priority routing behind an AHB-Lite slave
module can_interrupt_logic (
    // Clock and reset
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    clk_en,
    // AHB-Lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    // Events from the message core
    input  wire can_irq_pkg::mbox_evt_t  mbox_evt,
    input  wire can_irq_pkg::fault_evt_t fault_evt,
    input  wire can_irq_pkg::err_count_t err_count,
    input  wire logic                    powered_down,
    input  wire logic                    bus_rx,
    // Requests toward the expansion hub
    output can_irq_pkg::irq_req_t        mbox_irq,
    output can_irq_pkg::irq_req_t        fault_irq
);

    logic [5:0]  mb_flag_reg;
    logic [5:0]  mb_flag_next;
    logic [6:0]  fault_flag_reg;
    logic [6:0]  fault_flag_next;
    logic [15:0] mask_reg;
    logic [3:0]  rx_pend_reg;
    logic [3:0]  rx_pend_next;
    logic [3:0]  tx_pend_reg;
    logic [3:0]  tx_pend_next;
    logic [2:0]  wsel_reg;
    logic [15:0] rdata_reg;
    logic [2:0]  lvl_reg;
    logic [2:0]  lvl_now;
    logic        rx_meta_reg;
    logic        rx_sync_reg;
    logic        rx_prev_reg;
    logic        take;
    logic [15:0] wdata;
    logic [3:0]  rx_clr;
    logic [3:0]  tx_clr;
    logic [5:0]  mb_set;
    logic [5:0]  mb_clr;
    logic [6:0]  fault_set;
    logic [6:0]  fault_clr;
    logic        wake_set;
    logic        wake_async;
    logic        mbox_any;
    logic        fault_any;
    logic [15:0] flags_view;
    logic [15:0] done_view;

    function automatic logic [31:0] word_addr(input logic [15:0] idx);
        word_addr = {14'h0000, idx, 2'h0};
    endfunction

    function automatic logic [2:0] reg_select(input logic [31:0] a);
        reg_select = {a == word_addr(can_irq_pkg::DONE_IDX),
                      a == word_addr(can_irq_pkg::MASK_IDX),
                      a == word_addr(can_irq_pkg::FLAGS_IDX)};
    endfunction

    function automatic logic at_limit(input logic [8:0] v, input logic [8:0] lim);
        at_limit = v >= lim;
    endfunction

    // Bus slave: zero wait states, stalled only by the clock enable
    assign hreadyout = clk_en;
    assign hresp     = 1'b0;
    assign hrdata    = {16'h0000, rdata_reg};
    assign take      = hsel & hready & htrans[1] & (hsize == can_irq_pkg::HSIZE_WORD);
    assign wdata     = hwdata[15:0];

    assign flags_view = {2'h0, mb_flag_reg, 1'h0, fault_flag_reg};
    assign done_view  = {2'h0, tx_pend_reg, 6'h00, rx_pend_reg};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wsel_reg <= 3'h0;
        else if (clk_en)
            wsel_reg <= (take && hwrite) ? reg_select(haddr) : 3'h0;
    end

    // Read data sampled in the address phase; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_reg <= 16'h0000;
        else if (clk_en && take && !hwrite)
        begin
            case (reg_select(haddr))
                3'h1:    rdata_reg <= flags_view;
                3'h2:    rdata_reg <= mask_reg;
                3'h4:    rdata_reg <= done_view;
                default: rdata_reg <= 16'h0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mask_reg <= can_irq_pkg::MASK_RESET;
        else if (clk_en && wsel_reg[can_irq_pkg::SEL_MASK])
            mask_reg <= wdata & can_irq_pkg::MASK_WR_MASK;
    end

    // Pending bits: hardware sets, write one clears, set wins
    assign rx_clr = wsel_reg[can_irq_pkg::SEL_DONE] ? wdata[3:0] : 4'h0;
    assign tx_clr = wsel_reg[can_irq_pkg::SEL_DONE] ? wdata[13:10] : 4'h0;
    assign rx_pend_next = (rx_pend_reg & ~rx_clr) | mbox_evt.rx;
    assign tx_pend_next = (tx_pend_reg & ~tx_clr) | mbox_evt.tx;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_pend_reg <= can_irq_pkg::PEND_RESET;
            tx_pend_reg <= can_irq_pkg::PEND_RESET;
        end
        else if (clk_en)
        begin
            rx_pend_reg <= rx_pend_next;
            tx_pend_reg <= tx_pend_next;
        end
    end

    // Mailboxes 2 and 3 complete either way; an auto-reply send arrives as tx
    assign mb_set = {mbox_evt.tx[3:2], mbox_evt.tx[1:0] | mbox_evt.rx[3:2],
                     mbox_evt.rx[1:0]};
    assign mb_clr = {tx_clr[3:2], tx_clr[1:0] | rx_clr[3:2], rx_clr[1:0]};
    assign mb_flag_next = (mb_flag_reg & ~mb_clr) | (mb_set & mask_reg[13:8]);

    // Bus pin passes two flops before the wake flag logic sees it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            rx_meta_reg <= bus_rx;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
        end
    end

    assign wake_set = powered_down & rx_prev_reg & ~rx_sync_reg;

    assign lvl_now = {at_limit(err_count.send, can_irq_pkg::BUSOFF_LIMIT),
                      at_limit(err_count.send, can_irq_pkg::PASSIVE_LIMIT) |
                      at_limit({1'b0, err_count.recv}, can_irq_pkg::PASSIVE_LIMIT),
                      at_limit(err_count.send, can_irq_pkg::WARN_LIMIT) |
                      at_limit({1'b0, err_count.recv}, can_irq_pkg::WARN_LIMIT)};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            lvl_reg <= 3'h0;
        else if (clk_en)
            lvl_reg <= lvl_now;
    end

    // Entry into a state sets the flag once, not while it lasts
    assign fault_set = {fault_evt.rx_lost, fault_evt.abort, fault_evt.write_denied,
                        wake_set, lvl_now & ~lvl_reg};
    // Only software writes clear; acknowledge has no path here
    assign fault_clr = wsel_reg[can_irq_pkg::SEL_FLAGS] ? wdata[6:0] : 7'h00;
    assign fault_flag_next = (fault_flag_reg & ~fault_clr) | fault_set;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mb_flag_reg    <= can_irq_pkg::MBOX_FLAG_RESET;
            fault_flag_reg <= can_irq_pkg::FAULT_FLAG_RESET;
        end
        else if (clk_en)
        begin
            mb_flag_reg    <= mb_flag_next;
            fault_flag_reg <= fault_flag_next;
        end
    end

    // One level per line covers any number of set flags
    assign mbox_any  = |(mb_flag_reg & mask_reg[13:8]);
    assign fault_any = |(fault_flag_reg & mask_reg[6:0]);
    // Unclocked path: a stopped clock cannot sample the pin, the hub restarts it
    assign wake_async = powered_down & ~bus_rx & mask_reg[can_irq_pkg::WAKE_BIT];

    assign mbox_irq.high  = mbox_any & ~mask_reg[can_irq_pkg::MBOX_PRIO_BIT];
    assign mbox_irq.low   = mbox_any & mask_reg[can_irq_pkg::MBOX_PRIO_BIT];
    assign fault_irq.high = (fault_any | wake_async) &
                            ~mask_reg[can_irq_pkg::FAULT_PRIO_BIT];
    assign fault_irq.low  = (fault_any | wake_async) &
                            mask_reg[can_irq_pkg::FAULT_PRIO_BIT];

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_mb0_rx;
        clk_en && mbox_evt.rx[0] && mask_reg[8];
    endsequence

    sequence s_abort_clear;
        clk_en && wsel_reg[can_irq_pkg::SEL_FLAGS] && wdata[5] && fault_evt.abort;
    endsequence

    chk_mbox_route: assert property (s_mb0_rx ##1 !mask_reg[15] |-> mbox_irq.high)
        else $error("mailbox event did not raise mailbox request");

    chk_mask_gate: assert property (clk_en && mb_set != 6'h00 && mb_flag_reg == 6'h00
        && (mb_set & mask_reg[13:8]) == 6'h00 |=> mb_flag_reg == 6'h00)
        else $error("masked mailbox event set a flag");

    chk_hold_zero: assert property (clk_en && wsel_reg[0] && wdata[6:0] == 7'h00
        |=> (fault_flag_reg & $past(fault_flag_reg)) == $past(fault_flag_reg))
        else $error("writing zero cleared a flag");

    chk_mbox_ignore: assert property (clk_en && !wsel_reg[2] && mb_flag_reg[0]
        |=> mb_flag_reg[0])
        else $error("mailbox flag cleared without pending clear");

    chk_set_wins: assert property (s_abort_clear |=> fault_flag_reg[5])
        else $error("abort set lost against clear");

    chk_warn_level: assert property (clk_en && err_count.recv >= 8'h60 && !lvl_reg[0]
        |=> fault_flag_reg[0])
        else $error("warning level not flagged");

    // Passive flag comes with bus-off only when passive was not already reached
    chk_busoff_flag: assert property (clk_en && err_count.send >= 9'h100 && !lvl_reg[2]
        |=> fault_flag_reg[2] && (fault_flag_reg[1] || $past(lvl_reg[1])))
        else $error("bus-off entry not flagged");

    chk_passive_edge: assert property (clk_en && err_count.send == 9'h07F
        && err_count.recv < 8'h60 && !lvl_reg[1] |=> !fault_flag_reg[1] || $past(fault_flag_reg[1]))
        else $error("passive flagged below limit");

    chk_wake_flag: assert property (clk_en && powered_down && rx_prev_reg && !rx_sync_reg
        |=> fault_flag_reg[can_irq_pkg::WAKE_BIT])
        else $error("wake-up not flagged");

    chk_fault_prio: assert property (clk_en && fault_any && mask_reg[7]
        |-> fault_irq.low && !fault_irq.high)
        else $error("error request on wrong priority");

    chk_single_req: assert property (clk_en && mbox_any && mb_clr == 6'h00
        && !wsel_reg[1] |=> mbox_any)
        else $error("mailbox request dropped without clear");

    // Priority routing of both request pairs
    chk_mbox_low: assert property (mbox_any && mask_reg[15]
        |-> mbox_irq.low && !mbox_irq.high)
        else $error("mailbox request not on low priority");

    chk_mbox_high: assert property (mbox_any && !mask_reg[15]
        |-> mbox_irq.high && !mbox_irq.low)
        else $error("mailbox request not on high priority");

    chk_fault_high: assert property (fault_any && !mask_reg[7]
        |-> fault_irq.high && !fault_irq.low)
        else $error("error request not on high priority");

    chk_mbox_quiet: assert property (!mbox_any
        |-> !mbox_irq.high && !mbox_irq.low)
        else $error("mailbox request without enabled flag");

    chk_fault_quiet: assert property (!fault_any && !wake_async
        |-> !fault_irq.high && !fault_irq.low)
        else $error("error request without enabled flag");

    chk_wake_async: assert property (wake_async && !mask_reg[7]
        |-> fault_irq.high)
        else $error("wake-up did not reach error request");

    // Flag set and clear
    sequence s_abort_evt;
        clk_en && fault_evt.abort;
    endsequence

    sequence s_abort_clear_only;
        clk_en && wsel_reg[can_irq_pkg::SEL_FLAGS] && wdata[5] && !fault_evt.abort;
    endsequence

    chk_abort_set: assert property (s_abort_evt |=> fault_flag_reg[5])
        else $error("abort not flagged");

    chk_clear_works: assert property (s_abort_clear_only |=> !fault_flag_reg[5])
        else $error("write one did not clear flag");

    chk_lost_set: assert property (clk_en && fault_evt.rx_lost
        |=> fault_flag_reg[6])
        else $error("receive overwrite not flagged");

    chk_denied_set: assert property (clk_en && fault_evt.write_denied
        |=> fault_flag_reg[4])
        else $error("denied write not flagged");

    chk_ack_keeps: assert property (clk_en && !wsel_reg[0] && fault_flag_reg[5]
        |=> fault_flag_reg[5])
        else $error("flag cleared without software write");

    chk_pend_clear: assert property (clk_en && wsel_reg[2] && wdata[0] && !mbox_evt.rx[0]
        |=> !rx_pend_reg[0] && !mb_flag_reg[0])
        else $error("receive-pending clear did not clear flag");

    chk_tx_pend_set: assert property (clk_en && mbox_evt.tx[0]
        |=> tx_pend_reg[0])
        else $error("send-done not set");

    chk_mb_flag_tx: assert property (clk_en && mbox_evt.tx[3] && mask_reg[13]
        |=> mb_flag_reg[5])
        else $error("mailbox five completion not flagged");

    // Register access
    chk_mask_write: assert property (clk_en && wsel_reg[1]
        |=> mask_reg == ($past(wdata) & can_irq_pkg::MASK_WR_MASK))
        else $error("mask write not stored");

    chk_mask_rsvd: assert property (!mask_reg[14])
        else $error("reserved mask bit set");

    chk_flags_read: assert property (clk_en && take && !hwrite && reg_select(haddr) == 3'h1
        |=> hrdata[15:0] == $past(flags_view))
        else $error("flag read returned wrong value");

    // Low clock enable must hold the flag and mask registers
    chk_freeze_state: assert property (!clk_en
        |=> mb_flag_reg == $past(mb_flag_reg) && fault_flag_reg == $past(fault_flag_reg)
            && mask_reg == $past(mask_reg))
        else $error("state changed while frozen");

endmodule // can_interrupt_logic

// ### inc/can_irq_pkg.sv
// Register map, field layout and carrier types of the CAN interrupt logic
package can_irq_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] FLAGS_IDX = 16'h7109;
    localparam logic [15:0] MASK_IDX  = 16'h710A;
    localparam logic [15:0] DONE_IDX  = 16'h710B;

    // One-hot select positions
    localparam int SEL_FLAGS = 0;
    localparam int SEL_MASK  = 1;
    localparam int SEL_DONE  = 2;

    // Flag and mask bit positions
    localparam int WAKE_BIT       = 3;
    localparam int FAULT_PRIO_BIT = 7;
    localparam int MBOX_PRIO_BIT  = 15;

    // Reset values
    localparam logic [5:0]  MBOX_FLAG_RESET  = 6'h00;
    localparam logic [6:0]  FAULT_FLAG_RESET = 7'h00;
    localparam logic [15:0] MASK_RESET       = 16'h0000;
    localparam logic [3:0]  PEND_RESET       = 4'h0;

    // Writable bits of the mask register
    localparam logic [15:0] MASK_WR_MASK = 16'hBFFF;

    // Error counter limits
    localparam logic [8:0] WARN_LIMIT    = 9'h060;
    localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
    localparam logic [8:0] BUSOFF_LIMIT  = 9'h100;

    // Bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Mailbox completion strobes; tx bit 0 is mailbox 2
    typedef struct packed {
        logic [3:0] rx;
        logic [3:0] tx;
    } mbox_evt_t;

    // Error and status strobes
    typedef struct packed {
        logic rx_lost;
        logic abort;
        logic write_denied;
    } fault_evt_t;

    // Error counter values
    typedef struct packed {
        logic [8:0] send;
        logic [7:0] recv;
    } err_count_t;

    // One request line pair toward the expansion hub
    typedef struct packed {
        logic high;
        logic low;
    } irq_req_t;
endpackage

// ### verification/irq_hub_model.sv
// Expansion hub model: watches both request pairs and counts each assertion
module irq_hub_model (
    // Clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // Requests from the block
    input  wire can_irq_pkg::irq_req_t mbox_irq,
    input  wire can_irq_pkg::irq_req_t fault_irq,
    // Assertions seen, either priority
    output logic [7:0]                 mbox_rises,
    output logic [7:0]                 fault_rises
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mbox_any_reg;
    logic fault_any_reg;

    // Hub takes either level of each pair; its acknowledge never reaches the flags
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mbox_any_reg  <= 1'b0;
            fault_any_reg <= 1'b0;
            mbox_rises    <= 8'h00;
            fault_rises   <= 8'h00;
        end
        else
        begin
            mbox_any_reg  <= mbox_irq.high | mbox_irq.low;
            fault_any_reg <= fault_irq.high | fault_irq.low;
            // Counted per assertion, so a re-pulse per flag shows up
            if ((mbox_irq.high | mbox_irq.low) && !mbox_any_reg)
                mbox_rises <= mbox_rises + 8'h01;
            if ((fault_irq.high | fault_irq.low) && !fault_any_reg)
                fault_rises <= fault_rises + 8'h01;
        end
    end
endmodule // irq_hub_model

// ### verification/tb.sv
// Self-checking bench for the CAN interrupt flag, mask and priority logic
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] FL = can_irq_pkg::FLAGS_IDX;
    localparam logic [15:0] MK = can_irq_pkg::MASK_IDX;
    localparam logic [15:0] DN = can_irq_pkg::DONE_IDX;
    logic                   hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp, bus_rx;
    logic                   powered_down;
    logic [31:0]            haddr, hwdata, hrdata;
    logic [1:0]             htrans;
    logic [2:0]             hsize;
    can_irq_pkg::mbox_evt_t  mbox_evt;
    can_irq_pkg::fault_evt_t fault_evt;
    can_irq_pkg::err_count_t err_count;
    can_irq_pkg::irq_req_t   mbox_irq, fault_irq;
    logic [7:0]             mbox_rises, fault_rises, rises_before;
    logic [15:0]            rd;
    int                     n_errors, samples_checked;

    can_interrupt_logic dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .mbox_evt(mbox_evt), .fault_evt(fault_evt), .err_count(err_count),
        .powered_down(powered_down), .bus_rx(bus_rx), .mbox_irq(mbox_irq), .fault_irq(fault_irq));
    irq_hub_model hub (.hclk(hclk), .hresetn(hresetn), .mbox_irq(mbox_irq),
        .fault_irq(fault_irq), .mbox_rises(mbox_rises), .fault_rises(fault_rises));

    always #25 hclk = ~hclk;

    task automatic conclude();
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t register got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_irq(input can_irq_pkg::irq_req_t got, input logic [1:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t request got %b expected %b", $time, got, exp);
        end
    endtask

    // Bounded wait for hready at a rising edge
    task automatic wait_rdy();
        for (int i = 0; i < 20; i++)
        begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                return;
        end
        n_errors++;
        $display("CHECK FAILED %0t bus never ready", $time);
        conclude();
    endtask

    // Event strobe may ride in the data phase to collide with the clear
    task automatic bus_wr(input logic [15:0] idx, input logic [15:0] d,
                          input can_irq_pkg::fault_evt_t ev);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= 1'b1;
        haddr  <= {14'h0000, idx, 2'h0};
        wait_rdy();
        hsel      <= 1'b0;
        htrans    <= 2'h0;
        hwdata    <= {16'h0000, d};
        fault_evt <= ev;
        wait_rdy();
        fault_evt <= 3'h0;
    endtask

    task automatic bus_rd(input logic [15:0] idx, output logic [15:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= 1'b0;
        haddr  <= {14'h0000, idx, 2'h0};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        wait_rdy();
        d = hrdata[15:0];
    endtask

    // One-cycle strobes, then settle one cycle so requests are visible
    task automatic pulse(input logic [7:0] m, input logic [2:0] f);
        @(posedge hclk);
        mbox_evt  <= m;
        fault_evt <= f;
        @(posedge hclk);
        mbox_evt  <= 8'h00;
        fault_evt <= 3'h0;
        @(posedge hclk);
        #1;
    endtask

    task automatic test_reset();
        bus_rd(FL, rd); chk_reg(rd, 16'h0000);
        bus_rd(MK, rd); chk_reg(rd, 16'h0000);
        bus_wr(MK, 16'hFFFF, 3'h0);
        bus_rd(MK, rd); chk_reg(rd, 16'hBFFF);
    endtask

    task automatic test_fault();
        bus_wr(MK, 16'h007F, 3'h0);
        rises_before = fault_rises;
        pulse(8'h00, 3'h7);
        chk_irq(fault_irq, 2'b10);
        chk_irq(mbox_irq, 2'b00);
        chk_reg({8'h00, fault_rises - rises_before}, 16'h0001);
        bus_wr(FL, 16'h0000, 3'h0);
        bus_rd(FL, rd); chk_reg(rd, 16'h0070);
        bus_wr(FL, 16'h0030, 3'h0);
        bus_rd(FL, rd); chk_reg(rd, 16'h0040);
        bus_wr(MK, 16'h00FF, 3'h0);
        #1 chk_irq(fault_irq, 2'b01);
        bus_wr(MK, 16'h00BF, 3'h0);
        #1 chk_irq(fault_irq, 2'b00);
        bus_wr(FL, 16'h0040, 3'h0);
        // Set arriving with the clear must survive
        pulse(8'h00, 3'h2);
        bus_wr(FL, 16'h0020, 3'h2);
        bus_rd(FL, rd); chk_reg(rd, 16'h0020);
        bus_wr(FL, 16'h0020, 3'h0);
    endtask

    task automatic test_mbox();
        bus_wr(MK, 16'h8500, 3'h0);
        pulse(8'h21, 3'h0);
        chk_irq(mbox_irq, 2'b01);
        chk_irq(fault_irq, 2'b00);
        bus_rd(FL, rd); chk_reg(rd, 16'h0400);
        bus_rd(DN, rd); chk_reg(rd, 16'h0402);
        bus_wr(FL, 16'h3F00, 3'h0);
        bus_rd(FL, rd); chk_reg(rd, 16'h0400);
        bus_wr(DN, 16'h0402, 3'h0);
        bus_rd(FL, rd); chk_reg(rd, 16'h0000);
        chk_irq(mbox_irq, 2'b00);
        bus_wr(MK, 16'h0500, 3'h0);
        pulse(8'h11, 3'h0);
        chk_irq(mbox_irq, 2'b10);
        bus_rd(FL, rd); chk_reg(rd, 16'h0500);
        bus_wr(DN, 16'h0401, 3'h0);
        bus_rd(FL, rd); chk_reg(rd, 16'h0000);
    endtask

    // Frozen block ignores strobes and stalls the bus
    task automatic test_freeze();
        bus_wr(MK, 16'h007F, 3'h0);
        @(posedge hclk);
        clk_en <= 1'b0;
        pulse(8'h00, 3'h1);
        chk_reg({15'h0000, hreadyout}, 16'h0000);
        chk_irq(fault_irq, 2'b00);
        clk_en <= 1'b1;
        bus_rd(FL, rd); chk_reg(rd, 16'h0000);
    endtask

    task automatic test_levels();
        err_count <= 17'h0005F;
        bus_rd(FL, rd); chk_reg(rd, 16'h0000);
        err_count <= 17'h00060;
        bus_rd(FL, rd); chk_reg(rd, 16'h0001);
        bus_wr(FL, 16'h007F, 3'h0);
        err_count <= {9'h080, 8'h60};
        bus_rd(FL, rd); chk_reg(rd, 16'h0002);
        bus_wr(FL, 16'h007F, 3'h0);
        err_count <= {9'h100, 8'h60};
        bus_rd(FL, rd); chk_reg(rd, 16'h0004);
        bus_wr(FL, 16'h007F, 3'h0);
    endtask

    task automatic test_wake();
        bus_wr(MK, 16'h0008, 3'h0);
        powered_down <= 1'b1;
        bus_rx       <= 1'b0;
        #1 chk_irq(fault_irq, 2'b10);
        repeat (4) @(posedge hclk);
        bus_rd(FL, rd); chk_reg(rd, 16'h0008);
        powered_down <= 1'b0;
        bus_rx       <= 1'b1;
        bus_wr(FL, 16'h0008, 3'h0);
        bus_rd(FL, rd); chk_reg(rd, 16'h0000);
    endtask

    initial
    begin
        hclk = 1'b0; hresetn = 1'b0; clk_en = 1'b1; hsel = 1'b0; hwrite = 1'b0;
        haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0; hsize = can_irq_pkg::HSIZE_WORD;
        mbox_evt = 8'h00; fault_evt = 3'h0; err_count = 17'h0; powered_down = 1'b0;
        bus_rx = 1'b1; n_errors = 0; samples_checked = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset();
        test_fault();
        test_mbox();
        test_levels();
        test_wake();
        test_freeze();
        conclude();
    end
endmodule // tb
